/* File: include/tcsm_regs.vh */
/*
 Register map, field layout and mode encodings for the timer channel
 start-mode control block. Assumes inclusion by bare name from hw files.
*/
`ifndef TCSM_REGS_VH
`define TCSM_REGS_VH

// ----------------------------------------------------------------------
// Register indices (one 32-bit word each; byte address is four times the index)
// ----------------------------------------------------------------------
`define TCSM_MODE_BASE      20'hF0190
`define TCSM_MODE_LAST      20'hF019E
`define TCSM_CTRL_OFF       20'hF01A0
`define TCSM_STAT_OFF       20'hF01A4

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define TCSM_START_IRQ_BIT  0
`define TCSM_MODE_LSB       1
`define TCSM_MODE_MSB       3
`define TCSM_MODE_WIDTH     16
`define TCSM_MODE_RESET     16'h0000
`define TCSM_ADDR_LSB       1
`define TCSM_IDX_LSB        2
`define TCSM_PADDR_MSB      21

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define TCSM_MD_INTERVAL    3'h0
`define TCSM_MD_CAPTURE     3'h2
`define TCSM_MD_EVENT       3'h3
`define TCSM_MD_ONECOUNT    3'h4
`define TCSM_MD_CAP_ONE     3'h6

`endif

/* File: hw/tcsm_channel.v */
/*
 One timer channel: start/trigger handling per mode and start-interrupt bit.
 Assumes triggers and terminal-count are synchronous single-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tcsm_regs.vh"

module tcsm_channel #(
    parameter CNT_W = 16
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [2:0]       operating_mode_field,
    input  wire             start_interrupt_select,
    input  wire             enable,
    input  wire             start_trigger,
    input  wire [CNT_W-1:0] count_load,
    output reg              counting,
    output reg              timer_irq,
    output reg              timer_out,
    output reg  [CNT_W-1:0] count
);
    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    wire iv_cap  = (operating_mode_field == `TCSM_MD_INTERVAL) ||
                   (operating_mode_field == `TCSM_MD_CAPTURE);
    wire one_cnt = (operating_mode_field == `TCSM_MD_ONECOUNT);
    wire cap_one = (operating_mode_field == `TCSM_MD_CAP_ONE);
    wire one_shot = one_cnt || cap_one;
    // Start honoured when idle; retrigger only in one-count with bit set
    wire retrig  = one_cnt && start_interrupt_select;
    wire take    = start_trigger && (!counting || retrig);
    // Start interrupt only when idle start in interval/capture with bit set
    wire st_irq  = take && !counting && iv_cap && start_interrupt_select;
    wire at_end  = counting && (count == {CNT_W{1'b0}});

    // ------------------------------------------------------------------
    // Counter, interrupt and output
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counting  <= 1'b0;
            timer_irq <= 1'b0;
            timer_out <= 1'b0;
            count     <= {CNT_W{1'b0}};
        end else begin
            timer_irq <= 1'b0;
            if (!enable) begin
                counting <= 1'b0;
            end else if (take) begin
                counting <= 1'b1;                  // Restart reloads count
                count    <= count_load;
                if (st_irq) begin
                    timer_irq <= 1'b1;
                    timer_out <= ~timer_out;
                end
            end else if (at_end) begin
                // Terminal count: interrupt and toggle, one-shots stop
                timer_irq <= 1'b1;
                timer_out <= ~timer_out;
                if (one_shot) begin
                    counting <= 1'b0;
                end else begin
                    count <= count_load;
                end
            end else if (counting) begin
                count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/tcsm_top.v */
/*
 Eight-channel timer start-mode control with APB register access.
 Assumes a single pclk domain and triggers synchronous to pclk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tcsm_regs.vh"

module tcsm_top #(
    parameter NCH   = 8,
    parameter CNT_W = 16
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [21:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire [NCH-1:0]   start_trigger,
    output reg  [NCH-1:0]   timer_irq,
    output reg  [NCH-1:0]   timer_out
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg  [`TCSM_MODE_WIDTH-1:0] channel_mode_register [0:NCH-1];
    reg  [NCH-1:0]              chan_enable;
    wire [NCH-1:0]              ch_counting;
    wire [NCH-1:0]              ch_irq;
    wire [NCH-1:0]              ch_out;
    wire [CNT_W-1:0]            ch_count [0:NCH-1];
    integer                     i;

    // Channel number from a register index in the mode window
    function [2:0] mode_index;
        input [19:0] addr;
        begin
            mode_index = addr[`TCSM_ADDR_LSB+2:`TCSM_ADDR_LSB];
        end
    endfunction

    function is_mode_addr;
        input [19:0] addr;
        begin
            is_mode_addr = (addr >= `TCSM_MODE_BASE) && (addr <= `TCSM_MODE_LAST) &&
                           (addr[0] == 1'b0);
        end
    endfunction

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gen_ch
            tcsm_channel #(
                .CNT_W (CNT_W)
            ) u_ch (
                .pclk                   (pclk),
                .presetn                (presetn),
                .operating_mode_field   (channel_mode_register[g][`TCSM_MODE_MSB:`TCSM_MODE_LSB]),
                .start_interrupt_select (channel_mode_register[g][`TCSM_START_IRQ_BIT]),
                .enable                 (chan_enable[g]),
                .start_trigger          (start_trigger[g]),
                .count_load             (channel_mode_register[g]),
                .counting               (ch_counting[g]),
                .timer_irq              (ch_irq[g]),
                .timer_out              (ch_out[g]),
                .count                  (ch_count[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs re-registered so every top output comes from a flop
    // ------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= {NCH{1'b0}};
            timer_out <= {NCH{1'b0}};
        end else begin
            timer_irq <= ch_irq;
            timer_out <= ch_out;
        end
    end

    // ------------------------------------------------------------------
    // APB slave: zero wait states, error on unmapped address
    // ------------------------------------------------------------------
    // Word index of the access; sub-word byte addresses are refused
    wire [19:0] reg_idx  = paddr[`TCSM_PADDR_MSB:`TCSM_IDX_LSB];
    wire        word_ok  = (paddr[`TCSM_IDX_LSB-1:0] == 2'b00);
    wire        mode_hit = word_ok && is_mode_addr(reg_idx);
    wire        ctrl_hit = word_ok && (reg_idx == `TCSM_CTRL_OFF);
    wire        stat_hit = word_ok && (reg_idx == `TCSM_STAT_OFF);
    wire        access   = psel && penable;
    wire        mapped   = mode_hit || ctrl_hit || stat_hit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < NCH; i = i + 1) begin
                channel_mode_register[i] <= `TCSM_MODE_RESET;
            end
            chan_enable <= {NCH{1'b0}};
            prdata      <= 32'h00000000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            // Pready pulses in the first access cycle, so one wait-free answer
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (access && pready && pwrite) begin
                // Software is trusted to write only allowed settings
                if (mode_hit) begin
                    channel_mode_register[mode_index(reg_idx)] <= pwdata[`TCSM_MODE_WIDTH-1:0];
                end else if (ctrl_hit) begin
                    chan_enable <= pwdata[NCH-1:0];
                end
            end
            if (psel && !penable && !pwrite) begin
                if (mode_hit) begin
                    prdata <= {16'h0000, channel_mode_register[mode_index(reg_idx)]};
                end else if (ctrl_hit) begin
                    prdata <= {{(32-NCH){1'b0}}, chan_enable};
                end else if (stat_hit) begin
                    prdata <= {{(32-NCH){1'b0}}, ch_counting};
                end else begin
                    prdata <= 32'h00000000;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/tcsm_top_asserts.sv */
/* Port assertions for the timer start-mode block.
   Assumes one pclk domain and binding from the bench top file. */
`timescale 1ns/10ps
`default_nettype none
module tcsm_top_asserts #(
    parameter NCH = 8
) (
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [21:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic [NCH-1:0] start_trigger,
    input wire logic [NCH-1:0] timer_irq,
    input wire logic [NCH-1:0] timer_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------------------------------
    // Bus answer and channel outputs
    // ----------------------------------------------------------------
    sequence setup_s; psel && !penable; endsequence
    apb_ready_a: assert property (setup_s |=> pready) else $error("ready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_inside_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    bad_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper half set");
    irq_pulse_a: assert property (timer_irq != 0 |=> (timer_irq & $past(timer_irq)) == 0)
        else $error("irq longer than one cycle");
    // Output toggles exactly with irq; silent starts leave it alone
    irq_toggle_a: assert property ((timer_out ^ $past(timer_out)) == timer_irq)
        else $error("toggle without irq");
endmodule
`default_nettype wire

/* File: tb/tcsm_top_tb.sv */
/* Self-checking bench for the timer start-mode block.
   Drives APB and start triggers itself; no far-side model. */
`timescale 1ns/10ps
`default_nettype none
module tcsm_top_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [21:0] paddr;
    time         t_trig, t_first;
    // Register indices; the byte address is the index times four
    localparam logic [19:0] mode0_ix = 20'hF0190, mode7_ix = 20'hF019E;
    localparam logic [19:0] ctrl_ix = 20'hF01A0, stat_ix = 20'hF01A4;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  start_trigger, timer_irq, timer_out, acc;
    int          err_total, n_tests, k;
    // One mode per channel; the whole 16-bit word doubles as reload count
    logic [15:0] mode_tab [8] = '{16'h0040, 16'h0041, 16'h0044, 16'h0045,
                                  16'h0046, 16'h0048, 16'h0049, 16'h008C};
    tcsm_top #(.NCH(8), .CNT_W(16)) tcsm_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_trigger(start_trigger),
        .timer_irq(timer_irq), .timer_out(timer_out));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Ready and data are taken at the rising edge that ends the access
    task apb(input logic w, input logic [21:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20) begin err_total++; report_and_stop; end
    endtask
    // Pulse triggers, then gather irqs over the answer window
    task trig(input logic [7:0] v, input logic [7:0] exp);
        @(posedge pclk); start_trigger <= v;
        @(posedge pclk); start_trigger <= 8'h00;
        t_trig = $time;
        acc = 8'h00;
        repeat (3) begin @(negedge pclk); acc = acc | timer_irq; end
        chk({24'h0, acc}, {24'h0, exp});
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 22'h0;
        pwdata = 32'h0; start_trigger = 8'h00; err_total = 0; n_tests = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, {mode0_ix, 2'b00}, 32'h0); chk(rd, 32'h0000);
        apb(1'b0, {mode7_ix, 2'b00}, 32'h0); chk(rd, 32'h0000);
        apb(1'b0, 22'h3C0C00, 32'h0); chk({31'h0, er}, 32'h1);
        // Sub-word address inside the mode window is refused as well
        apb(1'b0, {mode0_ix, 2'b10}, 32'h0); chk({31'h0, er}, 32'h1);
        $display("test reset and map done");
        // Only allowed mode and start-bit pairs are written
        for (int i = 0; i < 8; i++)
            apb(1'b1, {mode0_ix + 20'(2 * i), 2'b00}, {16'h0, mode_tab[i]});
        apb(1'b0, {mode7_ix, 2'b00}, 32'h0); chk(rd, 32'h008C);
        apb(1'b1, {ctrl_ix, 2'b00}, 32'h00FF);
        trig(8'hFF, 8'h0A);
        t_first = t_trig;
        chk({24'h0, timer_out}, 32'h000A);
        $display("test start per mode done");
        repeat (20) @(posedge pclk);
        trig(8'hFF, 8'h00);
        k = 0;
        while (timer_irq[5] !== 1'b1 && k < 300) begin @(negedge pclk); k++; end
        if (k >= 300) err_total++;
        // Plain one-count ends its first run: reload count, end cycle, output flop
        chk(32'(($time - t_first) / 40), {16'h0, mode_tab[5]} + 32'h2);
        // Plain one-count has stopped; the restarted one-count still runs
        apb(1'b0, {stat_ix, 2'b00}, 32'h0); chk(rd, 32'h00DF);
        $display("test retrigger done");
        report_and_stop;
    end
endmodule
bind tcsm_top tcsm_top_asserts #(.NCH(NCH)) tcsm_top_asserts_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_trigger(start_trigger),
    .timer_irq(timer_irq), .timer_out(timer_out));
`default_nettype wire
